// ---- hdl/mac_side_control_status_regs.sv ----
// MAC-side control, FIFO interrupt and line loopback registers on AHB-Lite
module mac_side_control_status_regs (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_sw_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_fifo_err,
   input wire logic i_idle_ins,
   input wire logic i_idle_del,
   input wire logic i_power_down,
   input wire logic i_energy_detect,
   output logic o_pad_odd_preamble,
   output logic o_rx_clk_enable,
   output logic o_line_loopback,
   output logic o_irq
);

   function automatic logic reg_hit(input logic [9:0] addr,
                                    input logic [7:0] idx);
      reg_hit = (addr == {idx, 2'b00});
   endfunction

   mac_regs_pkg::bus_state_t st_r;
   mac_regs_pkg::bus_state_t st_nxt;
   logic [9:0] addr_r;
   logic [9:0] addr_nxt;
   logic ok_r;
   logic ok_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [15:0] ctrl1_r;
   logic [15:0] ctrl1_nxt;
   logic [15:0] ien_r;
   logic [15:0] ien_nxt;
   logic [15:0] stat_r;
   logic [15:0] stat_nxt;
   logic [15:0] ctrl2_r;
   logic [15:0] ctrl2_nxt;
   logic pass_act_r;
   logic pass_act_nxt;
   logic keep_act_r;
   logic keep_act_nxt;
   logic rxclk_r;
   logic rxclk_nxt;
   logic irq_r;
   logic irq_nxt;
   logic accept;
   logic wr_live;
   logic rd_live;
   logic [15:0] ev_set;
   logic [15:0] ev_clr;
   logic [15:0] rd_val;

   // Bus sequencing and register next values
   always_comb begin
      accept = i_hsel & i_htrans[1] & i_hready;
      st_nxt = st_r;
      addr_nxt = addr_r;
      ok_nxt = ok_r;
      rdata_nxt = rdata_r;
      ctrl1_nxt = ctrl1_r;
      ien_nxt = ien_r;
      ctrl2_nxt = ctrl2_r;
      pass_act_nxt = pass_act_r;
      keep_act_nxt = keep_act_r;
      ev_set = 16'h0000;
      ev_clr = 16'h0000;
      rd_val = 16'h0000;
      wr_live = (st_r == mac_regs_pkg::ST_WRITE) & ok_r;
      rd_live = (st_r == mac_regs_pkg::ST_RD_WAIT) & ok_r;

      case (st_r)
         mac_regs_pkg::ST_RD_WAIT: begin
            st_nxt = mac_regs_pkg::ST_RD_DONE;
         end
         mac_regs_pkg::ST_IDLE,
         mac_regs_pkg::ST_WRITE,
         mac_regs_pkg::ST_RD_DONE: begin
            if (accept) begin
               st_nxt = i_hwrite ? mac_regs_pkg::ST_WRITE
                                 : mac_regs_pkg::ST_RD_WAIT;
               addr_nxt = i_haddr[9:0];
               ok_nxt = (i_haddr[31:10] == 22'h000000) &&
                        (i_hsize == mac_regs_pkg::HSIZE_WORD);
            end else begin
               st_nxt = mac_regs_pkg::ST_IDLE;
            end
         end
         default: begin
            st_nxt = mac_regs_pkg::ST_IDLE;
         end
      endcase

      // Reserved CTRL1 bits are stored as written; CTRL2 keeps only its CTRL2_MASK bits
      if (wr_live && reg_hit(addr_r, mac_regs_pkg::CTRL1_IDX)) begin
         ctrl1_nxt = i_hwdata[15:0];
      end
      if (wr_live && reg_hit(addr_r, mac_regs_pkg::IEN_IDX)) begin
         ien_nxt = i_hwdata[15:0];
      end
      if (wr_live && reg_hit(addr_r, mac_regs_pkg::CTRL2_IDX)) begin
         ctrl2_nxt = i_hwdata[15:0] & mac_regs_pkg::CTRL2_MASK;
      end

      // Read value, sampled in the wait cycle
      if (reg_hit(addr_r, mac_regs_pkg::CTRL1_IDX)) begin
         rd_val = ctrl1_r;
      end else if (reg_hit(addr_r, mac_regs_pkg::IEN_IDX)) begin
         rd_val = ien_r;
      end else if (reg_hit(addr_r, mac_regs_pkg::STAT_IDX)) begin
         rd_val = stat_r;
      end else if (reg_hit(addr_r, mac_regs_pkg::CTRL2_IDX)) begin
         rd_val = ctrl2_r;
      end
      if (st_r == mac_regs_pkg::ST_RD_WAIT) begin
         rdata_nxt = ok_r ? {16'h0000, rd_val} : 32'h00000000;
      end

      // Latched FIFO events; a new event beats a clear in the same cycle
      ev_set[mac_regs_pkg::OVF_BIT] = i_fifo_err;
      ev_set[mac_regs_pkg::INS_BIT] = i_idle_ins;
      ev_set[mac_regs_pkg::DEL_BIT] = i_idle_del;
      if (rd_live && reg_hit(addr_r, mac_regs_pkg::STAT_IDX)) begin
         ev_clr = 16'hffff;
      end
      if (wr_live && reg_hit(addr_r, mac_regs_pkg::STAT_IDX)) begin
         ev_clr = ev_clr | i_hwdata[15:0];
      end

      // Software reset loads the update-type bits and clears status
      if (i_sw_rst) begin
         ev_clr = 16'hffff;
         ctrl2_nxt = mac_regs_pkg::CTRL2_RST;
         pass_act_nxt = ctrl1_nxt[mac_regs_pkg::PASS_ODD_BIT];
         keep_act_nxt = ctrl1_nxt[mac_regs_pkg::RXCLK_ON_BIT];
      end
      stat_nxt = ((stat_r & ~ev_clr) | ev_set) & mac_regs_pkg::STAT_MASK;

      rxclk_nxt = keep_act_nxt | ~(i_power_down | i_energy_detect);
      irq_nxt = |(stat_nxt & ien_nxt & mac_regs_pkg::STAT_MASK);
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= mac_regs_pkg::ST_IDLE;
         addr_r <= 10'h000;
         ok_r <= 1'b0;
         rdata_r <= 32'h00000000;
         ctrl1_r <= mac_regs_pkg::CTRL1_RST;
         ien_r <= mac_regs_pkg::IEN_RST;
         stat_r <= mac_regs_pkg::STAT_RST;
         ctrl2_r <= mac_regs_pkg::CTRL2_RST;
         pass_act_r <= mac_regs_pkg::CTRL1_RST[mac_regs_pkg::PASS_ODD_BIT];
         keep_act_r <= mac_regs_pkg::CTRL1_RST[mac_regs_pkg::RXCLK_ON_BIT];
         rxclk_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         ok_r <= ok_nxt;
         rdata_r <= rdata_nxt;
         ctrl1_r <= ctrl1_nxt;
         ien_r <= ien_nxt;
         stat_r <= stat_nxt;
         ctrl2_r <= ctrl2_nxt;
         pass_act_r <= pass_act_nxt;
         keep_act_r <= keep_act_nxt;
         rxclk_r <= rxclk_nxt;
         irq_r <= irq_nxt;
      end
   end

   // One wait state on reads so the read data come from a flip-flop
   assign o_hreadyout = (st_r != mac_regs_pkg::ST_RD_WAIT);
   assign o_hresp = mac_regs_pkg::HRESP_OKAY;
   assign o_hrdata = rdata_r;
   assign o_pad_odd_preamble = ~pass_act_r;
   assign o_rx_clk_enable = rxclk_r;
   assign o_line_loopback = ctrl2_r[mac_regs_pkg::LOOP_BIT];
   assign o_irq = irq_r;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   ovf_latch_a: assert property (
      i_fifo_err |=> stat_r[mac_regs_pkg::OVF_BIT] ##1
      (stat_r[mac_regs_pkg::OVF_BIT] || $past(ev_clr[7])))
      else $error("overflow flag not latched");

   ins_hold_a: assert property (
      (stat_r[mac_regs_pkg::INS_BIT] && !ev_clr[mac_regs_pkg::INS_BIT])
      |=> stat_r[mac_regs_pkg::INS_BIT])
      else $error("idle inserted flag dropped without a read");

   del_latch_a: assert property (
      i_idle_del |=> stat_r[mac_regs_pkg::DEL_BIT])
      else $error("idle deleted flag not set");

   stat_rdclr_a: assert property (
      (st_r == mac_regs_pkg::ST_RD_WAIT && ok_r &&
       reg_hit(addr_r, mac_regs_pkg::STAT_IDX) &&
       !i_fifo_err && !i_idle_ins && !i_idle_del)
      |=> (stat_r == 16'h0000) && (o_hrdata[15:0] == $past(stat_r)))
      else $error("status read did not return and clear flags");

   irq_level_a: assert property (
      o_irq == |(stat_r & ien_r & mac_regs_pkg::STAT_MASK))
      else $error("interrupt does not follow enabled flags");

   irq_rise_a: assert property (
      (i_idle_ins && ien_r[mac_regs_pkg::INS_BIT] && !wr_live)
      |=> o_irq)
      else $error("enabled idle insert did not raise interrupt");

   pad_swrst_a: assert property (
      (i_sw_rst && !wr_live)
      |=> o_pad_odd_preamble == !$past(ctrl1_r[mac_regs_pkg::PASS_ODD_BIT]))
      else $error("preamble mode not updated by software reset");

   keep_stable_a: assert property (
      !i_sw_rst |=> $stable(keep_act_r))
      else $error("clock power mode changed without software reset");

   rxclk_off_a: assert property (
      (!keep_act_r && !i_sw_rst && i_power_down) |=> !o_rx_clk_enable)
      else $error("receive clock kept on while allowed to stop");

   rxclk_on_a: assert property (
      (keep_act_r && !i_sw_rst) |=> o_rx_clk_enable)
      else $error("receive clock stopped while forced on");

   loop_write_a: assert property (
      (wr_live && reg_hit(addr_r, mac_regs_pkg::CTRL2_IDX) && !i_sw_rst)
      |=> o_line_loopback == $past(i_hwdata[mac_regs_pkg::LOOP_BIT]))
      else $error("line loopback does not follow written bit");

   rd_wait_a: assert property (
      (st_r == mac_regs_pkg::ST_RD_WAIT) |-> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state not exactly one cycle");

   ovf_set_wins_a: assert property (
      (i_fifo_err && ev_clr[mac_regs_pkg::OVF_BIT])
      |=> stat_r[mac_regs_pkg::OVF_BIT])
      else $error("overflow event lost to a clear");

   ovf_hold_a: assert property (
      (stat_r[mac_regs_pkg::OVF_BIT] && !ev_clr[mac_regs_pkg::OVF_BIT])
      |=> stat_r[mac_regs_pkg::OVF_BIT])
      else $error("overflow flag dropped without a read");

   ins_latch_a: assert property (
      i_idle_ins |=> stat_r[mac_regs_pkg::INS_BIT])
      else $error("idle inserted flag not set");

   del_hold_a: assert property (
      (stat_r[mac_regs_pkg::DEL_BIT] && !ev_clr[mac_regs_pkg::DEL_BIT])
      |=> stat_r[mac_regs_pkg::DEL_BIT])
      else $error("idle deleted flag dropped without a read");

   irq_mask_a: assert property (
      ((ien_r & mac_regs_pkg::STAT_MASK) == 16'h0000 && !wr_live)
      |=> !o_irq)
      else $error("interrupt raised with all sources disabled");

   pad_stable_a: assert property (
      !i_sw_rst |=> $stable(o_pad_odd_preamble))
      else $error("preamble mode changed without software reset");

   keep_swrst_a: assert property (
      (i_sw_rst && !wr_live)
      |=> keep_act_r == $past(ctrl1_r[mac_regs_pkg::RXCLK_ON_BIT]))
      else $error("clock power mode not loaded by software reset");

   rxclk_ed_off_a: assert property (
      (!keep_act_r && !i_sw_rst && i_energy_detect) |=> !o_rx_clk_enable)
      else $error("receive clock kept on in energy detect");

   rxclk_wake_a: assert property (
      (!keep_act_r && !i_sw_rst && !i_power_down && !i_energy_detect)
      |=> o_rx_clk_enable)
      else $error("receive clock off while device is awake");

   loop_swrst_a: assert property (
      i_sw_rst |=> !o_line_loopback)
      else $error("software reset left line loopback on");

endmodule // mac_side_control_status_regs

// ---- inc/mac_regs_pkg.sv ----
// Constants shared by the MAC-side control and status register block
package mac_regs_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;

   // Register indices; byte address is four times the index
   localparam logic [7:0] CTRL1_IDX = 8'h10;
   localparam logic [7:0] IEN_IDX = 8'h12;
   localparam logic [7:0] STAT_IDX = 8'h13;
   localparam logic [7:0] CTRL2_IDX = 8'h15;

   // Values after hardware reset
   localparam logic [15:0] CTRL1_RST = 16'h4448;
   localparam logic [15:0] IEN_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   localparam logic [15:0] CTRL2_RST = 16'h0000;

   // Implemented bits
   localparam logic [15:0] STAT_MASK = 16'h008c;
   localparam logic [15:0] CTRL2_MASK = 16'hc000;

   // Field positions
   localparam int PASS_ODD_BIT = 6;
   localparam int RXCLK_ON_BIT = 3;
   localparam int OVF_BIT = 7;
   localparam int INS_BIT = 3;
   localparam int DEL_BIT = 2;
   localparam int LOOP_BIT = 14;

   // Bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WRITE = 4'h2,
      ST_RD_WAIT = 4'h4,
      ST_RD_DONE = 4'h8
   } bus_state_t;
endpackage

// ---- tb/mac_far_end.sv ----
// MAC-side FIFO event source facing the register block
module mac_far_end (
   input wire logic i_core_clk,
   input wire logic [2:0] i_evt,
   output logic o_fifo_err,
   output logic o_idle_ins,
   output logic o_idle_del
);
   timeunit 1ns;
   timeprecision 1ps;
   // One-cycle event pulses, launched just after a rising edge
   always_ff @(posedge i_core_clk) begin
      {o_fifo_err, o_idle_ins, o_idle_del} <= i_evt;
   end
endmodule // mac_far_end

// ---- tb/tb_mac_side_control_status_regs.sv ----
// Self-checking bench for the MAC-side control and status registers
module tb_mac_side_control_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, sw = 0, hsel = 0, hwr = 0, pd = 0, ed = 0;
   logic [31:0] haddr = 0, hwd = 0, hrd;
   logic [1:0] htr = 0;
   logic [2:0] evt = 0;
   logic [2:0] hsz = 3'h2;
   logic rdy, resp, pad, rxen, loop, irq, fe, ii, id;
   int fails = 0, cmp_count = 0;
   always #2.5 clk = ~clk;
   mac_side_control_status_regs dut (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_sw_rst(sw), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htr),
      .i_hwrite(hwr), .i_hsize(hsz), .i_hwdata(hwd), .i_hready(rdy),
      .o_hrdata(hrd), .o_hreadyout(rdy), .o_hresp(resp), .i_fifo_err(fe),
      .i_idle_ins(ii), .i_idle_del(id), .i_power_down(pd),
      .i_energy_detect(ed), .o_pad_odd_preamble(pad),
      .o_rx_clk_enable(rxen), .o_line_loopback(loop), .o_irq(irq));
   mac_far_end mac (.i_core_clk(clk), .i_evt(evt), .o_fifo_err(fe),
      .o_idle_ins(ii), .o_idle_del(id));
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Ends at the edge where the slave shows ready
   task wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (rdy !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            summarize;
         end
         @(posedge clk);
      end
   endtask
   task bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
            output logic [31:0] r);
      hsel <= 1;
      htr <= 2'h2;
      hwr <= w;
      haddr <= {22'h0, idx, 2'h0};
      wait_rdy;
      hsel <= 0;
      htr <= 2'h0;
      hwd <= d;
      wait_rdy;
      r = hrd;
   endtask
   task wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 32'h0, r);
      chk(r, exp);
      chk(resp, 32'h0);
   endtask
   task soft_rst;
      sw <= 1;
      tick(1);
      sw <= 0;
      tick(2);
   endtask
   task t_reset;
      chk({pad, rxen, loop, irq}, 32'h4);
      rdc(mac_regs_pkg::CTRL1_IDX, 32'h4448);
      rdc(mac_regs_pkg::IEN_IDX, 32'h0);
      rdc(mac_regs_pkg::STAT_IDX, 32'h0);
      rdc(mac_regs_pkg::CTRL2_IDX, 32'h0);
      rdc(8'h11, 32'h0);
      // A narrow write is refused
      hsz <= 3'h1;
      wr(mac_regs_pkg::IEN_IDX, 32'h84);
      hsz <= 3'h2;
      rdc(mac_regs_pkg::IEN_IDX, 32'h0);
   endtask
   task t_ctrl1;
      wr(mac_regs_pkg::CTRL1_IDX, 32'h4400);
      tick(2);
      chk({pad, rxen}, 32'h1);
      soft_rst;
      chk(pad, 32'h1);
      pd <= 1;
      tick(3);
      chk(rxen, 32'h0);
      pd <= 0;
      ed <= 1;
      tick(3);
      chk(rxen, 32'h0);
      ed <= 0;
      tick(2);
      chk(rxen, 32'h1);
      wr(mac_regs_pkg::CTRL1_IDX, 32'h4448);
      pd <= 1;
      tick(3);
      chk({pad, rxen}, 32'h2);
      soft_rst;
      chk({pad, rxen}, 32'h1);
      pd <= 0;
   endtask
   // Clear by writing ones, and an event that meets a software reset
   task t_clear;
      evt <= 3'h2;
      tick(1);
      evt <= 3'h0;
      tick(3);
      wr(mac_regs_pkg::STAT_IDX, 32'h8);
      rdc(mac_regs_pkg::STAT_IDX, 32'h0);
      evt <= 3'h4;
      tick(1);
      evt <= 3'h0;
      sw <= 1;
      tick(1);
      sw <= 0;
      tick(2);
      rdc(mac_regs_pkg::STAT_IDX, 32'h80);
   endtask
   task t_events;
      int p[3];
      logic [31:0] b;
      p = '{mac_regs_pkg::OVF_BIT, mac_regs_pkg::INS_BIT,
            mac_regs_pkg::DEL_BIT};
      for (int i = 0; i < 3; i++) begin
         b = 32'h1 << p[i];
         wr(mac_regs_pkg::IEN_IDX, 32'h0);
         evt <= 3'h4 >> i;
         tick(1);
         evt <= 3'h0;
         tick(3);
         chk(irq, 32'h0);
         wr(mac_regs_pkg::IEN_IDX, b);
         tick(3);
         chk(irq, 32'h1);
         rdc(mac_regs_pkg::STAT_IDX, b);
         rdc(mac_regs_pkg::STAT_IDX, 32'h0);
         tick(3);
         chk(irq, 32'h0);
      end
   endtask
   task t_loop;
      wr(mac_regs_pkg::CTRL2_IDX, 32'h4000);
      tick(2);
      chk(loop, 32'h1);
      rdc(mac_regs_pkg::CTRL2_IDX, 32'h4000);
      wr(mac_regs_pkg::CTRL2_IDX, 32'h0);
      tick(2);
      chk(loop, 32'h0);
      wr(mac_regs_pkg::CTRL2_IDX, 32'h4000);
      soft_rst;
      chk(loop, 32'h0);
      rdc(mac_regs_pkg::CTRL2_IDX, 32'h0);
   endtask
   initial begin
      tick(20);
      rst_n <= 1;
      t_reset;
      t_ctrl1;
      t_events;
      t_clear;
      t_loop;
      summarize;
   end
endmodule // tb_mac_side_control_status_regs
